// *** cfs_alu.sv ***
// Single-cycle ALU with flag results
`timescale 1ns/1ps
module cfs_alu (
    // Operation
    input  wire logic [2:0] op,
    input  wire logic [7:0] a,
    input  wire logic [7:0] b,
    input  wire logic       cin,
    input  wire logic       hin,
    // Results
    output logic      [7:0] res,
    output logic            h,
    output logic            v,
    output logic            n,
    output logic            z,
    output logic            c
);
    logic [8:0] wide;
    logic [4:0] low;
    logic       cy;

    always_comb begin
        wide = 9'h000;
        low  = 5'h00;
        cy   = (op == cfs_pkg::ALU_ADC || op == cfs_pkg::ALU_SBC) ? cin
                                                                  : 1'b0;
        res  = 8'h00;
        h    = hin;
        v    = 1'b0;
        c    = cin;
        unique case (op)
            cfs_pkg::ALU_ADD, cfs_pkg::ALU_ADC: begin
                wide = {1'b0, a} + {1'b0, b} + {8'h00, cy};
                low  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cy};
                res  = wide[7:0];
                c    = wide[8];                                 // [RULE_07]
                h    = low[4];                                  // [RULE_04]
                v    = (a[7] == b[7]) && (res[7] != a[7]);      // [RULE_06]
            end
            cfs_pkg::ALU_SUB, cfs_pkg::ALU_SBC: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, cy};
                low  = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cy};
                res  = wide[7:0];
                c    = wide[8];                                 // [RULE_07]
                h    = low[4];                                  // [RULE_04]
                v    = (a[7] != b[7]) && (res[7] != a[7]);      // [RULE_06]
            end
            cfs_pkg::ALU_AND: res = a & b;
            cfs_pkg::ALU_OR:  res = a | b;
            cfs_pkg::ALU_XOR: res = a ^ b;
            default:          res = 8'h00;
        endcase
        n = res[7];                                             // [RULE_06]
        z = (res == 8'h00);                                     // [RULE_07]
    end
endmodule

// *** cfs_core.sv ***
// Flags register, register file, stack pointer and interrupt gate
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] Take irq only with enable and gate set
// [RULE_02] Gate cleared on take, set on return/unmask
// [RULE_03] Copy bit in and out via bit 6
// [RULE_04] Bit 5 records low-nibble carry
// [RULE_05] Bit 4 always equals negative xor overflow
// [RULE_06] Bit 3 overflow, bit 2 negative result
// [RULE_07] Bit 1 zero result, bit 0 carry
// [RULE_08] Flags updated after every ALU operation
// [RULE_09] Flags never saved or restored by hardware
// [RULE_10] Working registers mapped at data addresses 0-31
// [RULE_11] Byte and word read/write port combinations
// [RULE_12] Three pointer pairs: displacement, increment, decrement
// [RULE_13] Stack grows down, byte push/pop by one
// [RULE_14] Calls, irq entry, returns move stack by two
// [RULE_15] Software sets stack above 0x60 first
// [RULE_16] Undivided clock, ALU writeback in one cycle
// [RULE_17] Lower vector index wins, source zero first
// [RULE_18] Vectoring or written one clears irq flag
// [RULE_19] Disabled flags stay pending until served
// [RULE_20] Level sources request only while present
// [RULE_21] One instruction runs after return before irq
// [RULE_22] Mask blocks irq even in same cycle
// [RULE_23] One instruction runs after unmask before irq
// [RULE_24] Entry lasts four cycles after instruction completes
// [RULE_25] Reset clears flags and defines stack pointer
module cfs_core (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic        clk_en,
    // Instruction boundary
    input  wire logic        instr_valid,
    input  wire logic [3:0]  instr_op,
    input  wire logic [2:0]  alu_op,
    input  wire logic        use_imm,
    input  wire logic [7:0]  imm_data,
    input  wire logic [4:0]  rd_a_idx,
    input  wire logic [4:0]  rd_b_idx,
    input  wire logic [2:0]  bit_sel,
    // Byte operands
    output logic      [7:0]  rd_a_data,
    output logic      [7:0]  rd_b_data,
    // Word port
    input  wire logic [3:0]  pair_idx,
    input  wire logic        wr16_en,
    input  wire logic [15:0] wr16_data,
    output logic      [15:0] rd16_data,
    // Pointer addressing
    input  wire logic        ptr_go,
    input  wire logic [1:0]  ptr_sel,
    input  wire logic [1:0]  ptr_mode,
    input  wire logic [5:0]  ptr_disp,
    output logic      [15:0] ptr_addr,
    // Data space window onto the register file
    input  wire logic [15:0] ds_addr,
    input  wire logic        ds_wr,
    input  wire logic [7:0]  ds_wdata,
    output logic             ds_hit,
    output logic      [7:0]  ds_rdata,
    // I/O register port
    input  wire logic [5:0]  io_addr,
    input  wire logic        io_wr,
    input  wire logic [7:0]  io_wdata,
    output logic      [7:0]  io_rdata,
    // Interrupt sources and response
    input  wire logic [7:0]  irq_event,
    input  wire logic [7:0]  irq_level,
    output logic             irq_take,
    output logic      [2:0]  irq_idx,
    output logic             irq_busy,
    // State
    output logic      [7:0]  flags_out,
    output logic      [15:0] sp_out
);
    logic [7:0]          regs_r [cfs_pkg::REG_COUNT];
    logic [7:0]          regs_nxt [cfs_pkg::REG_COUNT];
    logic [7:0]          flags_r;
    logic [7:0]          flags_nxt;
    logic [15:0]         sp_r;
    logic [15:0]         sp_nxt;
    logic [7:0]          irq_en_r;
    logic [7:0]          irq_en_nxt;
    logic [7:0]          irq_flag_r;
    logic [7:0]          irq_flag_nxt;
    logic [2:0]          irq_idx_r;
    logic [2:0]          irq_idx_nxt;
    logic [2:0]          cnt_r;
    logic [2:0]          cnt_nxt;
    cfs_pkg::cfs_state_t state_r;
    cfs_pkg::cfs_state_t state_nxt;

    logic                exec;
    logic [7:0]          alu_b;
    logic [7:0]          alu_res;
    logic                alu_h;
    logic                alu_v;
    logic                alu_n;
    logic                alu_z;
    logic                alu_c;
    logic [7:0]          pending;
    logic [7:0]          take_clr;
    logic [7:0]          sw_clr;
    logic [2:0]          first_idx;
    logic                may_take;
    logic [4:0]          ptr_lo;
    logic [15:0]         ptr_cur;
    logic [15:0]         ptr_new;
    logic [7:0]          copy_byte;

    // Word of a register pair, given its low register
    function automatic logic [15:0] pair_word(input logic [4:0] lo);
        logic [4:0] hi;
        hi = 5'(lo + 5'h01);
        return {regs_r[hi], regs_r[lo]};
    endfunction

    // Index of the highest-priority set bit
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'h0;
        for (int i = cfs_pkg::IRQ_N - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    // Instructions count only while no interrupt entry is running
    assign exec = clk_en && instr_valid && (state_r == cfs_pkg::ST_RUN);

    assign alu_b = use_imm ? imm_data : regs_r[rd_b_idx];

    cfs_alu u_alu (
        .op  (alu_op),
        .a   (regs_r[rd_a_idx]),
        .b   (alu_b),
        .cin (flags_r[cfs_pkg::FB_CARRY]),
        .hin (flags_r[cfs_pkg::FB_HALF]),
        .res (alu_res),
        .h   (alu_h),
        .v   (alu_v),
        .n   (alu_n),
        .z   (alu_z),
        .c   (alu_c)
    );

    // Read ports
    assign rd_a_data = regs_r[rd_a_idx];                        // [RULE_11]
    assign rd_b_data = regs_r[rd_b_idx];                        // [RULE_11]
    assign rd16_data = pair_word({pair_idx, 1'b0});             // [RULE_11]
    assign ds_hit    = (ds_addr < cfs_pkg::DS_REG_LIMIT);       // [RULE_10]
    assign ds_rdata  = ds_hit ? regs_r[ds_addr[4:0]] : 8'h00;   // [RULE_10]

    // Pointer pairs sit above the 26th register
    assign ptr_lo  = 5'(cfs_pkg::PTR_BASE_IDX + {2'h0, ptr_sel, 1'b0});
    assign ptr_cur = pair_word(ptr_lo);

    always_comb begin
        ptr_addr = ptr_cur;
        ptr_new  = ptr_cur;
        unique case (ptr_mode)
            cfs_pkg::PM_DISP:    ptr_addr = ptr_cur + {10'h000, ptr_disp};
            cfs_pkg::PM_POSTINC: ptr_new  = ptr_cur + 16'h0001;  // [RULE_12]
            cfs_pkg::PM_PREDEC: begin
                ptr_new  = ptr_cur - 16'h0001;                  // [RULE_12]
                ptr_addr = ptr_new;
            end
            default:             ptr_addr = ptr_cur;
        endcase
    end

    always_comb begin
        copy_byte = regs_r[rd_a_idx];
        copy_byte[bit_sel] = flags_r[cfs_pkg::FB_COPY];         // [RULE_03]
    end

    // Register file writes; later sources override earlier ones
    always_comb begin
        for (int i = 0; i < cfs_pkg::REG_COUNT; i++) begin
            regs_nxt[i] = regs_r[i];
        end
        if (ds_wr && ds_hit) begin
            regs_nxt[ds_addr[4:0]] = ds_wdata;                  // [RULE_10]
        end
        if (wr16_en) begin
            regs_nxt[{pair_idx, 1'b0}] = wr16_data[7:0];        // [RULE_11]
            regs_nxt[{pair_idx, 1'b1}] = wr16_data[15:8];
        end
        if (ptr_go && ptr_mode != cfs_pkg::PM_DISP) begin
            regs_nxt[ptr_lo] = ptr_new[7:0];                    // [RULE_12]
            regs_nxt[5'(ptr_lo + 5'h01)] = ptr_new[15:8];
        end
        if (exec && instr_op == cfs_pkg::OP_ALU) begin
            regs_nxt[rd_a_idx] = alu_res;                       // [RULE_16]
        end
        if (exec && instr_op == cfs_pkg::OP_COPY_OUT) begin
            regs_nxt[rd_a_idx] = copy_byte;                     // [RULE_03]
        end
    end

    // Interrupt request resolution
    always_comb begin
        pending = irq_en_r & ((irq_flag_r & ~cfs_pkg::IRQ_LEVEL_MASK)
                  | (irq_level & cfs_pkg::IRQ_LEVEL_MASK));     // [RULE_20]
        first_idx = first_set(pending);                         // [RULE_17]
        // Return, unmask and mask must let the boundary pass untaken
        may_take = (instr_op != cfs_pkg::OP_MASK)               // [RULE_22]
                && (instr_op != cfs_pkg::OP_UNMASK)             // [RULE_23]
                && (instr_op != cfs_pkg::OP_RETURN_IRQ);        // [RULE_21]
        // Taken only at a completed instruction boundary
        irq_take = exec && may_take && (pending != 8'h00)       // [RULE_24]
                && flags_r[cfs_pkg::FB_GATE];                   // [RULE_01]
        take_clr = 8'h00;
        if (irq_take) begin
            take_clr[first_idx] = 1'b1;                         // [RULE_18]
        end
        take_clr = take_clr & ~cfs_pkg::IRQ_LEVEL_MASK;
        sw_clr = 8'h00;
        if (io_wr && io_addr == cfs_pkg::IO_IRQ_FLAG) begin
            sw_clr = io_wdata;                                  // [RULE_18]
        end
        // New event beats a same-cycle clear; flags hold until served
        irq_flag_nxt = (irq_flag_r & ~(take_clr | sw_clr))      // [RULE_19]
                     | (irq_event & ~cfs_pkg::IRQ_LEVEL_MASK);
        irq_en_nxt = irq_en_r;
        if (io_wr && io_addr == cfs_pkg::IO_IRQ_EN) begin
            irq_en_nxt = io_wdata;
        end
        irq_idx_nxt = irq_take ? first_idx : irq_idx_r;
    end

    // Entry sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        unique case (state_r)
            cfs_pkg::ST_RUN: begin
                if (irq_take) begin
                    state_nxt = cfs_pkg::ST_ENTRY;
                    cnt_nxt   = cfs_pkg::ENTRY_CYCLES;          // [RULE_24]
                end
            end
            cfs_pkg::ST_ENTRY: begin
                if (cnt_r == 3'h1) begin
                    state_nxt = cfs_pkg::ST_RUN;
                end
                cnt_nxt = cnt_r - 3'h1;
            end
            default: begin
                state_nxt = cfs_pkg::ST_RUN;
                cnt_nxt   = 3'h0;
            end
        endcase
    end

    // Flags register; entry and return leave it untouched apart from gate
    always_comb begin
        flags_nxt = flags_r;                                    // [RULE_09]
        if (exec) begin
            unique case (instr_op)
                cfs_pkg::OP_ALU: begin
                    flags_nxt[cfs_pkg::FB_HALF]  = alu_h;       // [RULE_08]
                    flags_nxt[cfs_pkg::FB_WRAP]  = alu_v;
                    flags_nxt[cfs_pkg::FB_NEG]   = alu_n;
                    flags_nxt[cfs_pkg::FB_NULL]  = alu_z;
                    flags_nxt[cfs_pkg::FB_CARRY] = alu_c;
                end
                cfs_pkg::OP_MASK:       flags_nxt[cfs_pkg::FB_GATE] = 1'b0;
                cfs_pkg::OP_UNMASK:     flags_nxt[cfs_pkg::FB_GATE] = 1'b1;
                cfs_pkg::OP_RETURN_IRQ: flags_nxt[cfs_pkg::FB_GATE] = 1'b1;
                cfs_pkg::OP_COPY_IN:
                    flags_nxt[cfs_pkg::FB_COPY] =
                        regs_r[rd_a_idx][bit_sel];              // [RULE_03]
                default:                flags_nxt = flags_r;
            endcase
        end
        if (io_wr && io_addr == cfs_pkg::IO_FLAGS) begin
            flags_nxt = io_wdata;
        end
        if (irq_take) begin
            flags_nxt[cfs_pkg::FB_GATE] = 1'b0;                 // [RULE_02]
        end
        // Sign is derived, so no write path can break it
        flags_nxt[cfs_pkg::FB_SIGN] = flags_nxt[cfs_pkg::FB_NEG]
                                    ^ flags_nxt[cfs_pkg::FB_WRAP]; // [RULE_05]
    end

    // Stack pointer; software must load it before calls or unmasking
    always_comb begin
        sp_nxt = sp_r;                                          // [RULE_15]
        if (io_wr && io_addr == cfs_pkg::IO_SP_HIGH) begin
            sp_nxt[15:8] = io_wdata;
        end
        if (io_wr && io_addr == cfs_pkg::IO_SP_LOW) begin
            sp_nxt[7:0] = io_wdata;
        end
        if (exec) begin
            unique case (instr_op)
                cfs_pkg::OP_PUSH1: sp_nxt = sp_r - 16'h0001;    // [RULE_13]
                cfs_pkg::OP_POP1:  sp_nxt = sp_r + 16'h0001;    // [RULE_13]
                cfs_pkg::OP_CALL:  sp_nxt = sp_r - 16'h0002;    // [RULE_14]
                cfs_pkg::OP_RET, cfs_pkg::OP_RETURN_IRQ:
                                   sp_nxt = sp_r + 16'h0002;    // [RULE_14]
                default:           sp_nxt = sp_nxt;
            endcase
        end
        if (irq_take) begin
            sp_nxt = sp_nxt - 16'h0002;                         // [RULE_14]
        end
    end

    always_comb begin
        unique case (io_addr)
            cfs_pkg::IO_FLAGS:    io_rdata = flags_r;
            cfs_pkg::IO_SP_HIGH:  io_rdata = sp_r[15:8];
            cfs_pkg::IO_SP_LOW:   io_rdata = sp_r[7:0];
            cfs_pkg::IO_IRQ_EN:   io_rdata = irq_en_r;
            cfs_pkg::IO_IRQ_FLAG: io_rdata = irq_flag_r;
            default:              io_rdata = 8'h00;
        endcase
    end

    // Runs on mclk directly; no divided clock anywhere
    always_ff @(posedge mclk or negedge reset_n) begin          // [RULE_16]
        if (!reset_n) begin
            for (int i = 0; i < cfs_pkg::REG_COUNT; i++) begin
                regs_r[i] <= 8'h00;
            end
            flags_r    <= cfs_pkg::FLAGS_RESET;                 // [RULE_25]
            sp_r       <= cfs_pkg::SP_RESET;                    // [RULE_25]
            irq_en_r   <= cfs_pkg::IRQ_EN_RESET;
            irq_flag_r <= 8'h00;
            irq_idx_r  <= 3'h0;
            cnt_r      <= 3'h0;
            state_r    <= cfs_pkg::ST_RUN;
        end else if (clk_en) begin
            for (int i = 0; i < cfs_pkg::REG_COUNT; i++) begin
                regs_r[i] <= regs_nxt[i];
            end
            flags_r    <= flags_nxt;
            sp_r       <= sp_nxt;
            irq_en_r   <= irq_en_nxt;
            irq_flag_r <= irq_flag_nxt;
            irq_idx_r  <= irq_idx_nxt;
            cnt_r      <= cnt_nxt;
            state_r    <= state_nxt;
        end
    end

    assign irq_idx   = irq_idx_r;
    assign irq_busy  = (state_r == cfs_pkg::ST_ENTRY);
    assign flags_out = flags_r;
    assign sp_out    = sp_r;
endmodule

// *** cfs_core_assertions.sv ***
// Port-level checks for the core
`timescale 1ns/1ps
module cfs_core_assertions (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    input wire logic        clk_en,
    // Boundary and interrupt
    input wire logic        instr_valid,
    input wire logic [3:0]  instr_op,
    input wire logic        io_wr,
    input wire logic        irq_take,
    input wire logic        irq_busy,
    // State and data window
    input wire logic [7:0]  flags_out,
    input wire logic [15:0] sp_out,
    input wire logic [15:0] ds_addr,
    input wire logic        ds_hit
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);
    logic go;
    // Boundary with no io write
    assign go = clk_en && instr_valid && !irq_busy && !io_wr;
    a_gate_needed:
    assert property (irq_take |-> flags_out[7])
        else $error("take with gate closed");
    a_take_closes_gate:
    assert property (irq_take |=> !flags_out[7])
        else $error("gate open after take");
    a_return_reopens:
    assert property (go && instr_op == cfs_pkg::OP_RETURN_IRQ |=>
        flags_out[7] && sp_out == $past(sp_out) + 16'h0002)
        else $error("bad irq return");
    a_sign_is_xor:
    assert property (flags_out[4] == (flags_out[2] ^ flags_out[3]))
        else $error("sign not n xor v");
    a_mask_blocks:
    assert property (instr_valid && instr_op == cfs_pkg::OP_MASK |-> !irq_take)
        else $error("take at mask");
    a_entry_length:
    assert property (irq_take |=> irq_busy [*4] ##1 !irq_busy)
        else $error("bad entry length");
    a_push_one:
    assert property (go && !irq_take && instr_op == cfs_pkg::OP_PUSH1 |=>
        sp_out == $past(sp_out) - 16'h0001)
        else $error("bad byte push");
    a_ds_window:
    assert property (ds_hit == (ds_addr < 16'h0020))
        else $error("bad window decode");
    a_no_take_busy:
    assert property (irq_busy |-> !irq_take)
        else $error("take during entry");
endmodule

bind cfs_core cfs_core_assertions u_chk (.*);

// *** cfs_core_test.sv ***
// Self-checking bench for the core
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module cfs_core_test;
    logic mclk, reset_n, instr_valid, wr16_en, ptr_go, ds_wr, io_wr;
    logic [3:0] instr_op, pair_idx, fire, lvl;
    logic [2:0] alu_op, bit_sel, irq_idx;
    logic [4:0] rd_a_idx, rd_b_idx;
    logic [1:0] ptr_sel, ptr_mode;
    logic [5:0] ptr_disp, io_addr;
    logic [15:0] wr16_data, ds_addr, rd16_data, ptr_addr, sp_out, sp, e;
    logic [7:0] ds_wdata, io_wdata, rd_a_data, ds_rdata, io_rdata, flags_out;
    logic [7:0] irq_event, irq_level, a, b, r, f, rd_b_data;
    logic ds_hit, irq_take, irq_busy, c, h, v;
    logic [31:0] seed;
    int fail_count, cmp_count, k, sel_q[$];
    logic [15:0] exp_q[$];
    cfs_core cfs_core_inst (.mclk, .reset_n, .clk_en(1'b1), .instr_valid,
        .instr_op, .alu_op, .use_imm(1'b0), .imm_data(8'h00), .rd_a_idx,
        .rd_b_idx, .bit_sel, .rd_a_data, .rd_b_data, .pair_idx, .wr16_en,
        .wr16_data, .rd16_data, .ptr_go, .ptr_sel, .ptr_mode, .ptr_disp,
        .ptr_addr, .ds_addr, .ds_wr, .ds_wdata, .ds_hit, .ds_rdata, .io_addr,
        .io_wr, .io_wdata, .io_rdata, .irq_event, .irq_level, .irq_take,
        .irq_idx, .irq_busy, .flags_out, .sp_out);
    cfs_irq_src cfs_irq_src_inst (.mclk, .reset_n, .fire, .lvl, .irq_event,
        .irq_level);
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    function automatic logic [15:0] obs(input int s);
        case (s)
            0: return {8'h00, flags_out};
            1: return sp_out;
            2: return {8'h00, rd_a_data};
            3: return {15'h0000, irq_take};
            4: return {13'h0000, irq_idx};
            5: return {8'h00, io_rdata};
            6: return {8'h00, ds_rdata};
            7: return rd16_data;
            8: return ptr_addr;
            10: return {8'h00, rd_b_data};
            default: return {15'h0000, irq_busy};
        endcase
    endfunction
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    task automatic ex(input int s, input logic [15:0] val);
        sel_q.push_back(s);
        exp_q.push_back(val);
    endtask
    task automatic at();
        @(negedge mclk);
    endtask
    task automatic nx();
        at();
        {instr_valid, wr16_en, ptr_go, ds_wr, io_wr} = 5'h00;
        fire = 4'h0;
    endtask
    task automatic go(input logic [3:0] o, input logic [2:0] ao = 3'h0);
        at();
        instr_op = o;
        alu_op = ao;
        instr_valid = 1'b1;
    endtask
    task automatic iow(input logic [5:0] ad, input logic [7:0] d);
        at();
        io_addr = ad;
        io_wdata = d;
        io_wr = 1'b1;
        nx();
    endtask
    task end_sim;
        if (fail_count == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Checks notes once outputs settle
    initial forever begin
        at();
        #1;
        while (exp_q.size() > 0) begin
            k = sel_q.pop_front();
            e = exp_q.pop_front();
            `CHK(obs(k), e)
        end
    end
    initial begin
        #40000;
        fail_count++;
        end_sim;
    end
    initial begin
        seed = 32'h0000102E;
        reset_n = 1'b0;
        {instr_valid, wr16_en, ptr_go, ds_wr, io_wr} = 5'h00;
        {instr_op, alu_op, rd_a_idx, rd_b_idx, bit_sel, pair_idx} = '0;
        {ptr_sel, ptr_mode, ptr_disp, io_addr, io_wdata} = '0;
        {wr16_data, ds_addr, ds_wdata, fire, lvl} = '0;
        repeat (16) @(posedge mclk);
        at();
        reset_n = 1'b1;
        io_addr = cfs_pkg::IO_FLAGS;
        ex(0, 16'h0000);
        ex(1, 16'h0000);
        // Stack above 0x60 first
        iow(cfs_pkg::IO_SP_HIGH, 8'h02);
        iow(cfs_pkg::IO_SP_LOW, 8'h10);
        sp = 16'h0210;
        ex(1, sp);
        for (int i = 0; i < 4; i++) begin
            go(i == 0 ? cfs_pkg::OP_PUSH1 : i == 1 ? cfs_pkg::OP_POP1 :
               i == 2 ? cfs_pkg::OP_CALL : cfs_pkg::OP_RET);
            nx();
            sp = sp + (i == 0 ? 16'hFFFF : i == 1 ? 16'h0001 :
                       i == 2 ? 16'hFFFE : 16'h0002);
            ex(1, sp);
        end
        f = 8'h00;
        rd_b_idx = 5'h01;
        for (int i = 0; i < 10; i++) begin
            a = rnd();
            b = (i == 9) ? a : rnd();
            at();
            wr16_data = {b, a};
            wr16_en = 1'b1;
            nx();
            go(cfs_pkg::OP_ALU, i[0] ? cfs_pkg::ALU_SUB : cfs_pkg::ALU_ADD);
            nx();
            {c, r} = i[0] ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
            h = i[0] ? (b[3:0] > a[3:0]) : ({1'b0, a[3:0]} + b[3:0] > 5'h0F);
            v = (a[7] ^ b[7] ^ !i[0]) && (r[7] != a[7]);
            f = {f[7:6], h, r[7] ^ v, v, r[7], r == 8'h00, c};
            ex(2, 16'(r));
            ex(10, 16'(b));
            ex(0, 16'(f));
        end
        at();
        pair_idx = 4'hD;
        wr16_data = 16'h1234;
        wr16_en = 1'b1;
        ptr_disp = 6'h05;
        nx();
        ex(8, 16'h1239);
        at();
        ptr_mode = cfs_pkg::PM_POSTINC;
        ptr_go = 1'b1;
        ex(8, 16'h1234);
        at();
        ex(7, 16'h1235);
        ptr_mode = cfs_pkg::PM_PREDEC;
        ex(8, 16'h1234);
        nx();
        ds_addr = 16'h001A;
        ex(6, 16'h0034);
        at();
        ds_addr = 16'h0020;
        ex(6, 16'h0000);
        at();
        ds_addr = 16'h001B;
        ds_wdata = 8'h77;
        ds_wr = 1'b1;
        nx();
        ex(7, 16'h7734);
        rd_a_idx = 5'h1A;
        bit_sel = 3'h2;
        go(cfs_pkg::OP_COPY_IN);
        nx();
        f[6] = 1'b1;
        ex(0, 16'(f));
        rd_a_idx = 5'h02;
        bit_sel = 3'h5;
        go(cfs_pkg::OP_COPY_OUT);
        fire = 4'h3;
        nx();
        ex(2, 16'h0020);
        iow(cfs_pkg::IO_IRQ_EN, 8'h13);
        io_addr = cfs_pkg::IO_IRQ_FLAG;
        ex(5, 16'h0003);
        go(cfs_pkg::OP_NOP);
        ex(3, 16'h0000);
        go(cfs_pkg::OP_UNMASK);
        ex(3, 16'h0000);
        for (int j = 0; j < 2; j++) begin
            go(cfs_pkg::OP_NOP);
            ex(3, 16'h0001);
            nx();
            sp = sp - 16'h0002;
            ex(4, 16'(j));
            ex(0, {8'h00, f});
            ex(1, sp);
            ex(5, j ? 16'h0000 : 16'h0002);
            repeat (3) nx();
            ex(9, 16'h0001);
            nx();
            ex(9, 16'h0000);
            go(cfs_pkg::OP_RETURN_IRQ);
            ex(3, 16'h0000);
            nx();
            sp = sp + 16'h0002;
            ex(1, sp);
            ex(0, {8'h00, f | 8'h80});
        end
        lvl = 4'h1;
        nx();
        go(cfs_pkg::OP_MASK);
        ex(3, 16'h0000);
        nx();
        lvl = 4'h0;
        ex(0, {8'h00, f});
        go(cfs_pkg::OP_UNMASK);
        nx();
        go(cfs_pkg::OP_NOP);
        ex(3, 16'h0000);
        fire = 4'h4;
        nx();
        nx();
        ex(5, 16'h0004);
        iow(cfs_pkg::IO_IRQ_FLAG, 8'h04);
        io_addr = cfs_pkg::IO_IRQ_FLAG;
        ex(5, 16'h0000);
        repeat (2) at();
        end_sim;
    end
endmodule

// *** cfs_irq_src.sv ***
// Peripheral interrupt sources facing the core
`timescale 1ns/1ps
module cfs_irq_src (
    // Clock and reset
    input wire logic  mclk,
    input wire logic  reset_n,
    // Commands from the bench
    input wire logic  [3:0] fire,
    input wire logic  [3:0] lvl,
    // Requests to the core
    output logic      [7:0] irq_event,
    output logic      [7:0] irq_level
);
    // Events pulse for each cycle fire is held; levels last while held
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            irq_event <= 8'h00;
            irq_level <= 8'h00;
        end else begin
            irq_event <= {4'h0, fire};
            irq_level <= {lvl, 4'h0};
        end
    end
endmodule

// *** cfs_pkg.sv ***
// Shared constants and types for the flags, stack and interrupt core
package cfs_pkg;

    // Working register file
    localparam int          REG_COUNT     = 32;
    localparam logic [15:0] DS_REG_LIMIT  = 16'h0020;
    localparam logic [4:0]  PTR_BASE_IDX  = 5'h1A;

    // Flags register bit positions
    localparam int FB_GATE  = 7;
    localparam int FB_COPY  = 6;
    localparam int FB_HALF  = 5;
    localparam int FB_SIGN  = 4;
    localparam int FB_WRAP  = 3;
    localparam int FB_NEG   = 2;
    localparam int FB_NULL  = 1;
    localparam int FB_CARRY = 0;

    // Values after reset
    localparam logic [7:0]  FLAGS_RESET  = 8'h00;
    localparam logic [15:0] SP_RESET     = 16'h0000;
    localparam logic [7:0]  IRQ_EN_RESET = 8'h00;

    // Register offsets in the I/O space
    localparam logic [5:0] IO_FLAGS    = 6'h3F;
    localparam logic [5:0] IO_SP_HIGH  = 6'h3E;
    localparam logic [5:0] IO_SP_LOW   = 6'h3D;
    localparam logic [5:0] IO_IRQ_EN   = 6'h3B;
    localparam logic [5:0] IO_IRQ_FLAG = 6'h3A;

    // Interrupt sources; set mask bits mark level-type sources
    localparam int         IRQ_N          = 8;
    localparam logic [7:0] IRQ_LEVEL_MASK = 8'hF0;

    // Interrupt entry length in cycles
    localparam logic [2:0] ENTRY_CYCLES = 3'h4;

    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_ALU        = 4'h1,
        OP_MASK       = 4'h2,
        OP_UNMASK     = 4'h3,
        OP_RETURN_IRQ = 4'h4,
        OP_COPY_IN    = 4'h5,
        OP_COPY_OUT   = 4'h6,
        OP_PUSH1      = 4'h7,
        OP_POP1       = 4'h8,
        OP_CALL       = 4'h9,
        OP_RET        = 4'hA
    } cfs_op_t;

    typedef enum logic [2:0] {
        ALU_ADD = 3'h0,
        ALU_ADC = 3'h1,
        ALU_SUB = 3'h2,
        ALU_SBC = 3'h3,
        ALU_AND = 3'h4,
        ALU_OR  = 3'h5,
        ALU_XOR = 3'h6
    } cfs_alu_t;

    typedef enum logic [1:0] {
        PM_DISP    = 2'h0,
        PM_POSTINC = 2'h1,
        PM_PREDEC  = 2'h2
    } cfs_pmode_t;

    typedef enum logic [1:0] {
        ST_RUN   = 2'b01,
        ST_ENTRY = 2'b10
    } cfs_state_t;

endpackage
